// ===== rtl/fixed_pulse.v
/*
 * Fixed-width pulse generator: a trigger starts a pulse of WIDTH clocks.
 * Triggers during a pulse are ignored so the width never changes.
 * Assumes WIDTH is at least one.
 */
`default_nettype none

module fixed_pulse #(
   parameter WIDTH = 16
) (
   input wire pclk,
   input wire presetn,
   input wire trigger,
   output reg pulse_q
);

   localparam CW = 6;
   localparam integer LAST_I = WIDTH - 1;
   // last count of the pulse, cut to the counter width on purpose
   localparam [CW-1:0] LAST = LAST_I[CW-1:0];

   reg [CW-1:0] cnt_q;

   // ----------------------------------------------------------------
   // pulse timer
   // ----------------------------------------------------------------
   // count up while active, drop after exactly WIDTH clocks
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pulse_q <= 1'b0;
         cnt_q <= {CW{1'b0}};
      end else if (pulse_q) begin
         if (cnt_q == LAST) begin
            pulse_q <= 1'b0;
            cnt_q <= {CW{1'b0}};
         end else begin
            cnt_q <= cnt_q + {{(CW-1){1'b0}}, 1'b1};
         end
      end else if (trigger) begin
         pulse_q <= 1'b1;
         cnt_q <= {CW{1'b0}};
      end
   end

endmodule

`default_nettype wire

// ===== rtl/raster_counter.v
/*
 * Pixel and line counters for the raster. Pixel count runs from zero
 * and wraps at the line total; each wrap advances the line count, which
 * wraps at the field total. Assumes totals are stable during a line.
 */
`default_nettype none

module raster_counter #(
   parameter HW = 11,
   parameter VW = 10
) (
   input wire pclk,
   input wire presetn,
   input wire [HW-1:0] h_total,
   input wire [VW-1:0] v_total,
   output reg [HW-1:0] pix_q,
   output reg [VW-1:0] line_q
);

   wire pix_wrap;
   wire line_wrap;

   // a total of zero or one keeps the counter at zero
   assign pix_wrap = ({1'b0, pix_q} + {{HW{1'b0}}, 1'b1}) >= {1'b0, h_total};
   assign line_wrap = ({1'b0, line_q} + {{VW{1'b0}}, 1'b1}) >= {1'b0, v_total};

   // ----------------------------------------------------------------
   // counters
   // ----------------------------------------------------------------
   // pixel count every clock, line count on each pixel wrap
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pix_q <= {HW{1'b0}};
         line_q <= {VW{1'b0}};
      end else if (pix_wrap) begin
         pix_q <= {HW{1'b0}};
         line_q <= line_wrap ? {VW{1'b0}} : line_q + {{(VW-1){1'b0}}, 1'b1};
      end else begin
         pix_q <= pix_q + {{(HW-1){1'b0}}, 1'b1};
      end
   end

endmodule

`default_nettype wire

// ===== rtl/video_timing.v
/*
 * Raster timing block: APB register file with line and frame timing
 * registers, pixel/line counters, line sync, frame retrace, fixed-width
 * line retrace pulse and display enable.
 * Assumes pclk is the pixel clock and an APB master drives the bus.
 */
// The implementer's own choice: the APB register port.
`default_nettype none
`include "video_timing_consts.vh"

// Overview of operation
// - line sync goes active when pixel count equals sync start field.
// - line sync goes inactive when pixel count equals sync end field.
// - field line total comes from the 10-bit total in frame limits.
// - frame retrace begins when line count equals retrace begin field.
// - frame retrace ends when line count equals retrace finish field.
// - line retrace pulse starts at pixel equal to retrace start field.
// - line retrace pulse always lasts exactly sixteen pixel clocks.
// - line pixel total comes from an 11-bit software field.
// - only pixels below the line display end field are displayed.
module video_timing #(
   parameter AW = 12,
   parameter HW = 11,
   parameter VW = 10,
   parameter RETRACE_CYCLES = `LINE_RETRACE_CYCLES
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [AW-1:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   output reg line_sync,
   output reg frame_retrace,
   output wire line_retrace,
   output reg display_enable
);

   // ----------------------------------------------------------------
   // helper functions
   // ----------------------------------------------------------------
   // pixel field of a register word
   function [HW-1:0] pix_field;
      input [31:0] word;
      input [4:0] lsb;
      begin
         pix_field = word[lsb +: HW];
      end
   endfunction

   // line field of a register word
   function [VW-1:0] line_field;
      input [31:0] word;
      input [4:0] lsb;
      begin
         line_field = word[lsb +: VW];
      end
   endfunction

   // address decode: true for any mapped offset
   function is_mapped;
      input [AW-1:0] a;
      begin
         case (a)
            `OFS_LINE_TOTAL_DISPLAY_LIMITS,
            `OFS_LINE_SYNC_EDGES,
            `OFS_FRAME_LINE_LIMITS,
            `OFS_FRAME_RETRACE_EDGES,
            `OFS_LINE_RETRACE_START,
            `OFS_RASTER_STATUS: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
         endcase
      end
   endfunction

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   reg [31:0] line_total_display_limits_q;
   reg [31:0] line_sync_edges_q;
   reg [31:0] frame_line_limits_q;
   reg [31:0] frame_retrace_edges_q;
   reg [31:0] line_retrace_start_q;
   reg [31:0] rdata_d;
   reg line_sync_d;
   reg frame_retrace_d;

   wire setup_phase;
   wire access_done;
   wire wr_hit;
   wire [HW-1:0] pix;
   wire [VW-1:0] line;
   wire [HW-1:0] h_total;
   wire [HW-1:0] h_display_end;
   wire [HW-1:0] sync_start;
   wire [HW-1:0] sync_end;
   wire [VW-1:0] v_total;
   wire [VW-1:0] frame_display_end;
   wire [VW-1:0] frame_retrace_begin;
   wire [VW-1:0] frame_retrace_finish;
   wire [HW-1:0] retrace_start;
   wire [31:0] status_word;

   // ----------------------------------------------------------------
   // apb handshake
   // ----------------------------------------------------------------
   assign setup_phase = psel & ~penable;
   assign access_done = psel & penable & pready;
   assign wr_hit = access_done & pwrite;

   // ready rises for the first access cycle: no wait states, but from a flop
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= `RESET_WORD;
      end else begin
         pready <= setup_phase;
         if (setup_phase) begin
            pslverr <= ~is_mapped(paddr);
            prdata <= pwrite ? `RESET_WORD : rdata_d;
         end else if (access_done) begin
            pslverr <= 1'b0;
            prdata <= `RESET_WORD;
         end
      end
   end

   // ----------------------------------------------------------------
   // register file
   // ----------------------------------------------------------------
   // writes keep only field bits, so reserved bits stay zero
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         line_total_display_limits_q <= `RESET_WORD;
         line_sync_edges_q <= `RESET_WORD;
         frame_line_limits_q <= `RESET_WORD;
         frame_retrace_edges_q <= `RESET_WORD;
         line_retrace_start_q <= `RESET_WORD;
      end else if (wr_hit) begin
         case (paddr)
            `OFS_LINE_TOTAL_DISPLAY_LIMITS:
               line_total_display_limits_q <= pwdata & `MASK_PIXEL_PAIR;
            `OFS_LINE_SYNC_EDGES:
               line_sync_edges_q <= pwdata & `MASK_PIXEL_PAIR;
            `OFS_FRAME_LINE_LIMITS:
               frame_line_limits_q <= pwdata & `MASK_LINE_PAIR;
            `OFS_FRAME_RETRACE_EDGES:
               frame_retrace_edges_q <= pwdata & `MASK_LINE_PAIR;
            `OFS_LINE_RETRACE_START:
               line_retrace_start_q <= pwdata & `MASK_PIXEL_LOW;
            default: begin
            end
         endcase
      end
   end

   // live raster state: pixel low, line high, flags at the top
   assign status_word = {line_sync, frame_retrace, line_retrace, display_enable,
                         {(12 - VW){1'b0}}, line, {(16 - HW){1'b0}}, pix};

   // read mux; unmapped offsets read zero
   always @* begin
      case (paddr)
         `OFS_LINE_TOTAL_DISPLAY_LIMITS: rdata_d = line_total_display_limits_q;
         `OFS_LINE_SYNC_EDGES: rdata_d = line_sync_edges_q;
         `OFS_FRAME_LINE_LIMITS: rdata_d = frame_line_limits_q;
         `OFS_FRAME_RETRACE_EDGES: rdata_d = frame_retrace_edges_q;
         `OFS_LINE_RETRACE_START: rdata_d = line_retrace_start_q;
         `OFS_RASTER_STATUS: rdata_d = status_word;
         default: rdata_d = `RESET_WORD;
      endcase
   end

   // ----------------------------------------------------------------
   // field extraction
   // ----------------------------------------------------------------
   assign h_total = pix_field(line_total_display_limits_q, `POS_HIGH_FIELD);
   assign h_display_end = pix_field(line_total_display_limits_q, `POS_LOW_FIELD);
   assign sync_start = pix_field(line_sync_edges_q, `POS_HIGH_FIELD);
   assign sync_end = pix_field(line_sync_edges_q, `POS_LOW_FIELD);
   assign v_total = line_field(frame_line_limits_q, `POS_HIGH_FIELD);
   assign frame_display_end = line_field(frame_line_limits_q, `POS_LOW_FIELD);
   assign frame_retrace_begin = line_field(frame_retrace_edges_q, `POS_HIGH_FIELD);
   assign frame_retrace_finish = line_field(frame_retrace_edges_q, `POS_LOW_FIELD);
   assign retrace_start = pix_field(line_retrace_start_q, `POS_LOW_FIELD);

   // ----------------------------------------------------------------
   // raster counters
   // ----------------------------------------------------------------
   raster_counter #(
      .HW(HW),
      .VW(VW)
   ) u_counter (
      .pclk(pclk),
      .presetn(presetn),
      .h_total(h_total),
      .v_total(v_total),
      .pix_q(pix),
      .line_q(line)
   );

   // ----------------------------------------------------------------
   // sync and retrace edges
   // ----------------------------------------------------------------
   // end match wins when start and end are equal: output stays inactive
   always @* begin
      line_sync_d = line_sync;
      if (pix == sync_end) begin
         line_sync_d = 1'b0;
      end else if (pix == sync_start) begin
         line_sync_d = 1'b1;
      end
      frame_retrace_d = frame_retrace;
      if (line == frame_retrace_finish) begin
         frame_retrace_d = 1'b0;
      end else if (line == frame_retrace_begin) begin
         frame_retrace_d = 1'b1;
      end
   end

   // outputs registered one clock after the counter match
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         line_sync <= 1'b0;
         frame_retrace <= 1'b0;
         display_enable <= 1'b0;
      end else begin
         line_sync <= line_sync_d;
         frame_retrace <= frame_retrace_d;
         display_enable <= (pix < h_display_end) & (line < frame_display_end);
      end
   end

   // ----------------------------------------------------------------
   // fixed-width line retrace
   // ----------------------------------------------------------------
   fixed_pulse #(
      .WIDTH(RETRACE_CYCLES)
   ) u_retrace (
      .pclk(pclk),
      .presetn(presetn),
      .trigger(pix == retrace_start),
      .pulse_q(line_retrace)
   );

endmodule

`default_nettype wire

// ===== rtl/video_timing_consts.vh
/*
 * Constants for the raster timing block: register byte offsets, field
 * positions and write masks, reset values and the fixed retrace width.
 * Assumes a 32-bit APB register bus and one pixel-rate clock.
 */
`ifndef VIDEO_TIMING_CONSTS_VH
`define VIDEO_TIMING_CONSTS_VH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define OFS_LINE_TOTAL_DISPLAY_LIMITS 12'h15c
`define OFS_LINE_SYNC_EDGES 12'h160
`define OFS_FRAME_LINE_LIMITS 12'h164
`define OFS_FRAME_RETRACE_EDGES 12'h168
`define OFS_LINE_RETRACE_START 12'h16c
`define OFS_RASTER_STATUS 12'h180

// ----------------------------------------------------------------------
// field positions (bit 0 is the least significant bit of the word)
// ----------------------------------------------------------------------
`define POS_HIGH_FIELD 5'h10
`define POS_LOW_FIELD 5'h00
`define POS_STATUS_FLAGS 5'h1c

// ----------------------------------------------------------------------
// writable bits per register; all other bits are reserved
// ----------------------------------------------------------------------
`define MASK_PIXEL_PAIR 32'h07ff07ff
`define MASK_LINE_PAIR 32'h03ff03ff
`define MASK_PIXEL_LOW 32'h000007ff

// ----------------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------------
`define RESET_WORD 32'h00000000
`define LINE_RETRACE_CYCLES 16

`endif

// ===== testbench/video_sink.sv
/* display-side sink: measures run lengths and spacing of the raster levels.
   assumes the levels are sampled on the rising pixel clock. */
`default_nettype none
module video_sink (
   input wire logic pclk,
   input wire logic line_sync,
   input wire logic frame_retrace,
   input wire logic line_retrace,
   input wire logic display_enable,
   output logic [31:0] sync_len,
   output logic [31:0] sync_per,
   output logic [31:0] retr_len,
   output logic [31:0] retr_off,
   output logic [31:0] frame_len,
   output logic [31:0] de_len,
   output logic [31:0] de_gap
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] sh = 0, sp = 0, rh = 0, fh = 0, dh = 0, dl = 0;
   // a run is recorded at the first sample after it ends
   always @(posedge pclk) begin
      sh <= line_sync ? sh + 1 : 0;
      if (!line_sync && sh != 0) sync_len <= sh;
      sp <= (line_sync && sh == 0) ? 1 : sp + 1;
      if (line_sync && sh == 0) sync_per <= sp;
      rh <= line_retrace ? rh + 1 : 0;
      if (!line_retrace && rh != 0) retr_len <= rh;
      if (line_retrace && rh == 0) retr_off <= sp;
      fh <= frame_retrace ? fh + 1 : 0;
      if (!frame_retrace && fh != 0) frame_len <= fh;
      dh <= display_enable ? dh + 1 : 0;
      if (!display_enable && dh != 0) de_len <= dh;
      dl <= display_enable ? 0 : dl + 1;
      if (display_enable && dl != 0) de_gap <= dl;
   end
endmodule
`default_nettype wire

// ===== testbench/video_timing_bench.sv
/* self-checking bench for the raster timing block over APB.
   assumes the design and its constants header are compiled first. */
`default_nettype none
`include "video_timing_consts.vh"
module video_timing_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk, presetn, psel, penable, pwrite, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, r, prdata;
   logic pready, pslverr, line_sync, frame_retrace, line_retrace, display_enable;
   logic [31:0] sync_len, sync_per, retr_len, retr_off, frame_len, de_len, de_gap;
   int n_errors = 0, num_checks = 0, i;
   logic [31:0] mk [5] = '{32'h07ff07ff, 32'h07ff07ff, 32'h03ff03ff, 32'h03ff03ff, 32'h000007ff};
   logic [31:0] rs [2] = '{32'h00000014, 32'h00000005};
   logic [31:0] off [2] = '{32'h0000001c, 32'h0000000d};
   video_timing DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .line_sync(line_sync), .frame_retrace(frame_retrace),
      .line_retrace(line_retrace), .display_enable(display_enable));
   video_sink sink (.pclk(pclk), .line_sync(line_sync), .frame_retrace(frame_retrace),
      .line_retrace(line_retrace), .display_enable(display_enable), .sync_len(sync_len),
      .sync_per(sync_per), .retr_len(retr_len), .retr_off(retr_off),
      .frame_len(frame_len), .de_len(de_len), .de_gap(de_gap));
   // pixel clock
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // counts and verdict
   task summarize;
      $display("errors %0d checks %0d", n_errors, num_checks);
      if (n_errors == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // one APB transfer; answer left in r and e
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) n_errors++;
   endtask
   // bounded wait for frame retrace or display enable to reach a level
   task wait_lvl(input logic fr, input logic v);
      int n;
      n = 0;
      while ((fr ? frame_retrace : display_enable) !== v && n < 2000) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 2000) n_errors++;
   endtask
   // ------------------------------------------------------------------
   // test sequence
   // ------------------------------------------------------------------
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      // reset value, write mask and reserved bits of each of the five writable registers (not status)
      for (i = 0; i < 5; i++) begin
         apb(1'b0, `OFS_LINE_TOTAL_DISPLAY_LIMITS + 4 * i, 32'h0);
         chk(r, 32'h0);
         apb(1'b1, `OFS_LINE_TOTAL_DISPLAY_LIMITS + 4 * i, 32'hffffffff);
         chk(e, 32'h0);
         apb(1'b0, `OFS_LINE_TOTAL_DISPLAY_LIMITS + 4 * i, 32'h0);
         chk(r, mk[i]);
      end
      // unmapped place errors and reads zero; status ignores writes quietly
      apb(1'b1, 12'h170, 32'hffffffff);
      chk(e, 32'h1);
      apb(1'b0, 12'h170, 32'h0);
      chk(r, 32'h0);
      apb(1'b1, `OFS_RASTER_STATUS, 32'hffffffff);
      chk(e, 32'h0);
      // 40 pixels, 30 shown; 12 lines, 8 shown; sync 32..36; retrace lines 9..11
      apb(1'b1, `OFS_LINE_TOTAL_DISPLAY_LIMITS, 32'h0028001e);
      apb(1'b1, `OFS_LINE_SYNC_EDGES, 32'h00200024);
      apb(1'b1, `OFS_FRAME_LINE_LIMITS, 32'h000c0008);
      apb(1'b1, `OFS_FRAME_RETRACE_EDGES, 32'h0009000b);
      for (i = 0; i < 2; i++) begin
         apb(1'b1, `OFS_LINE_RETRACE_START, rs[i]);
         wait_lvl(1'b1, 1'b0);
         wait_lvl(1'b1, 1'b1);
         wait_lvl(1'b0, 1'b1);
         repeat (2) @(posedge pclk);
         chk(sync_len, 32'h4);
         chk(sync_per, 32'h28);
         chk(retr_len, 32'h10);
         chk(retr_off, off[i]);
         chk(frame_len, 32'h50);
         chk(de_gap, 32'haa);
         chk(de_len, 32'h1e);
      end
      apb(1'b0, `OFS_RASTER_STATUS, 32'h0);
      chk(r[10:0] < 11'h028, 32'h1);
      chk(r[25:16] < 10'h00c, 32'h1);
      summarize;
   end
   // watchdog
   initial begin
      #200us;
      n_errors++;
      summarize;
   end
endmodule
bind video_timing video_timing_props #(.AW(AW), .RETRACE_CYCLES(RETRACE_CYCLES)) chk_i (
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
   .pslverr, .line_sync, .frame_retrace, .line_retrace, .display_enable);
`default_nettype wire

// ===== testbench/video_timing_props.sv
/* checker for the raster timing block: APB answer and line retrace width.
   assumes it is bound to the top module and sees only its ports. */
`default_nettype none
`include "video_timing_consts.vh"
module video_timing_props #(
   parameter AW = 12,
   parameter RETRACE_CYCLES = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic line_sync,
   input wire logic frame_retrace,
   input wire logic line_retrace,
   input wire logic display_enable
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] run_q;
   logic mapped;
   // length of the line retrace pulse seen so far
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_q <= 8'h00;
      end else begin
         run_q <= line_retrace ? run_q + 8'h01 : 8'h00;
      end
   end
   // addresses that hold a register
   assign mapped = paddr == `OFS_LINE_TOTAL_DISPLAY_LIMITS || paddr == `OFS_LINE_SYNC_EDGES
      || paddr == `OFS_FRAME_LINE_LIMITS || paddr == `OFS_FRAME_RETRACE_EDGES
      || paddr == `OFS_LINE_RETRACE_START || paddr == `OFS_RASTER_STATUS;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_access;
      psel && penable;
   endsequence
   chk_zero_wait: assert property (s_setup ##1 s_access |-> pready)
      else $error("no ready in first access cycle");
   chk_ready_access: assert property (pready |-> psel && penable)
      else $error("ready outside an access");
   chk_ready_once: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   chk_err_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   chk_unmapped_err: assert property (s_access and pready && !mapped |-> pslverr)
      else $error("unmapped access without error");
   chk_mapped_ok: assert property (pready && mapped |-> !pslverr)
      else $error("error on a mapped register");
   chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside an access");
   chk_retrace_width: assert property ($fell(line_retrace) |-> run_q == RETRACE_CYCLES)
      else $error("line retrace pulse width wrong");
   chk_retrace_cap: assert property (line_retrace |-> run_q < RETRACE_CYCLES)
      else $error("line retrace pulse too long");
endmodule
`default_nettype wire
